/* File: rtl/fasd_pkg.sv */
// Package with register map, field positions, reset values and duty constants
package fasd_pkg;
    // Register offsets
    localparam logic [7:0] ALARM_STATUS_TWO_ADDR = 8'h03;
    localparam logic [7:0] PWM_DUTY_CODE_ADDR = 8'h22;
    // Reset values
    localparam logic [7:0] ALARM_STATUS_TWO_RST = 8'h00;
    localparam logic [7:0] PWM_DUTY_CODE_RST = 8'h55;
    // Status field positions
    localparam int EXT_OVERTEMP_BIT = 7;
    localparam int LOCAL_SHUTDOWN_BIT = 6;
    localparam int PASSIVE_COOLING_BIT = 5;
    localparam int LOCAL_CRITICAL_BIT = 4;
    localparam int REMOTE_CRITICAL_BIT = 3;
    // Reserved low bits of the status register
    localparam logic [2:0] STATUS_RESERVED_VAL = 3'h0;
    // Duty code limits
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam int DUTY_STEPS = 255;
    // Shutdown re-arm hysteresis in degrees C
    localparam int SHUTDOWN_HYST_DEGC = 5;
    // Speed regulation floor and low-duty cutoff in percent
    localparam int RPM_FLOOR_PCT = 30;
    localparam int LOW_CUTOFF_PCT = 7;
    // Floor as a duty code, rounded up so the output never falls below it
    localparam logic [7:0] RPM_FLOOR_CODE = 8'((RPM_FLOOR_PCT * DUTY_STEPS + 99) / 100);
    // Cutoff threshold scaled by 100 for an exact compare
    localparam logic [15:0] LOW_CUTOFF_X100 = 16'(LOW_CUTOFF_PCT * DUTY_STEPS);
    // Fan control modes
    typedef enum logic [1:0] {
        FASD_MODE_AUTO = 2'b00,
        FASD_MODE_RPM = 2'b01,
        FASD_MODE_DIRECT = 2'b10,
        FASD_MODE_SPARE = 2'b11
    } fasd_mode_t;
endpackage

/* File: rtl/fasd_pwm.sv */
// Pulse width generator with a 255-count period
`timescale 1ns/10ps
module fasd_pwm import fasd_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] duty, // Applied duty code
    output logic pwm_out // Registered pulse output
);
    logic [WIDTH-1:0] cnt_reg; // Period counter, 0 to full minus one

    // Counter wraps one below the full code so the full code gives a solid high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (cnt_reg == WIDTH'(DUTY_STEPS - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + WIDTH'(1);
        end
    end

    // High for duty counts out of the period
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt_reg < duty);
        end
    end
endmodule

/* File: rtl/fasd_top.sv */
// Second alarm status register and duty code register of the fan controller
// Overview of operation
// - Pin pulled low sets flag, fan full
// - Read clears external flag; reasserts while low
// - Shutdown flag above limit; drives throttle pin
// - Shutdown flag raises alert when enabled
// - First status read clears shutdown flag
// - Shutdown flag rearms after 5 degree drop
// - Passive flag when control temp at/below threshold
// - Passive alert when enabled; read clears
// - Local critical flag at or above limit
// - Critical flag drives overlimit pin, unmaskable alert
// - Read clears local critical; reasserts next cycle
// - Remote critical flag, overlimit pin, alert
// - Read clears remote critical; reasserts next cycle
// - Three low status bits read zero
// - Duty code linear, full code full duty
// - Duty register resets to 0x55
// - Duty read returns applied duty
// - Regulation floor at 30 percent, read computed
// - Below 7 percent forced off, read computed
// - Direct mode writes set output duty
// - Other modes buffer write until direct
`timescale 1ns/10ps
module fasd_top import fasd_pkg::*; (
    input wire logic sys_clk, // 40 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr_stb, // One-cycle write strobe
    input wire logic reg_rd_stb, // One-cycle read strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Registered read data
    input wire logic status_one_rd_stb, // Read of the first status register
    input wire logic monitor_tick, // One pulse per monitoring cycle
    input wire logic signed [7:0] local_temp, // Local temperature, degrees C
    input wire logic signed [7:0] remote_temp, // Remote temperature, degrees C
    input wire logic signed [7:0] control_temp, // Active control temperature
    input wire logic signed [7:0] local_shutdown_limit, // Local shutdown limit
    input wire logic signed [7:0] local_critical_limit, // Local critical limit
    input wire logic signed [7:0] remote_critical_limit, // Remote critical limit
    input wire logic signed [7:0] passive_temp, // Passive cooling temperature
    input wire logic shutdown_alert_enable, // Enables shutdown alert
    input wire logic passive_alert_enable, // Enables passive alert
    input wire logic tach_sense_select, // Tach sensing select
    input wire logic [1:0] control_mode, // Fan control mode
    input wire logic [7:0] loop_duty, // Duty computed by auto or speed loop
    input wire logic overtemp_throttle_pin_in, // Throttle pin level seen
    output logic overtemp_throttle_pin_out, // Throttle pin drive value
    output logic overtemp_throttle_pin_oe_n, // Throttle pin enable, low drives
    output logic overlimit_pin_n, // Overlimit pin, active low
    output logic smbalert_n, // Alert output, active low
    output logic pulse_output_pin, // PWM fan drive
    output logic [7:0] applied_duty // Duty code on the PWM output
);
    logic [7:0] status_reg; // Status flags, low bits unused
    logic [7:0] status_next; // Next status flags
    logic shutdown_armed_reg; // Shutdown flag may set
    logic [7:0] duty_shadow_reg; // Last written duty code
    logic [7:0] computed_duty; // Duty before floor and cutoff
    logic [7:0] duty_out_next; // Duty after floor and cutoff
    logic [7:0] duty_readback; // Value returned on duty reads
    logic duty_forced; // Floor or cutoff replaced the computed value
    logic ext_low; // Pin pulled low by another party
    logic status_rd; // Read of this status register
    logic duty_wr; // Write of the duty register
    logic local_over_shutdown; // Local above shutdown limit
    logic local_cooled; // Local at least hysteresis below limit
    logic passive_cond; // Control temp at or below passive temp
    logic local_crit_cond; // Local at or above critical
    logic remote_crit_cond; // Remote at or above critical
    logic alert_next; // Alert level before the flop
    logic overlimit_next; // Overlimit level before the flop
    logic full_speed; // Fan forced to full speed
    fasd_mode_t mode; // Decoded control mode

    assign mode = fasd_mode_t'(control_mode);
    assign status_rd = reg_rd_stb && (reg_addr == ALARM_STATUS_TWO_ADDR);
    // Writes to the status offset match nothing, so they are dropped
    assign duty_wr = reg_wr_stb && (reg_addr == PWM_DUTY_CODE_ADDR);

    // Our own drive would read back as low, so only count foreign pulls
    assign ext_low = !overtemp_throttle_pin_in && overtemp_throttle_pin_oe_n;

    // Temperature compares, widened so the hysteresis cannot wrap
    always_comb begin
        // Strictly above: a reading at the limit does not trip
        local_over_shutdown = (local_temp > local_shutdown_limit);
        local_cooled = (9'(signed'(local_temp)) <=
            9'(signed'(local_shutdown_limit)) - 9'(SHUTDOWN_HYST_DEGC));
        // Remaining compares include the limit itself
        passive_cond = (control_temp <= passive_temp);
        local_crit_cond = (local_temp >= local_critical_limit);
        remote_crit_cond = (remote_temp >= remote_critical_limit);
    end

    // Flag update: condition loss and read clear first, then sets win
    always_comb begin
        status_next = status_reg;
        // Reads clear after the read data captured the old value
        if (status_rd) begin
            status_next[EXT_OVERTEMP_BIT] = 1'b0;
            status_next[PASSIVE_COOLING_BIT] = 1'b0;
            status_next[LOCAL_CRITICAL_BIT] = 1'b0;
            status_next[REMOTE_CRITICAL_BIT] = 1'b0;
        end
        // Shutdown flag is not cleared by this read; the first status register read clears it
        if (status_one_rd_stb) begin
            status_next[LOCAL_SHUTDOWN_BIT] = 1'b0;
        end
        // Conditions are sampled once per monitoring cycle
        if (monitor_tick) begin
            if (!local_over_shutdown) begin
                // Back under the limit, so the flag drops at once
                status_next[LOCAL_SHUTDOWN_BIT] = 1'b0;
            end else if (shutdown_armed_reg) begin
                // Over the limit and rearmed
                status_next[LOCAL_SHUTDOWN_BIT] = 1'b1;
            end
            // Other flags simply follow their conditions
            status_next[PASSIVE_COOLING_BIT] = passive_cond;
            status_next[LOCAL_CRITICAL_BIT] = local_crit_cond;
            status_next[REMOTE_CRITICAL_BIT] = remote_crit_cond;
        end
        // External pull is a live level, set in any cycle
        if (ext_low) begin
            status_next[EXT_OVERTEMP_BIT] = 1'b1;
        end
        status_next[2:0] = STATUS_RESERVED_VAL;
    end

    // Status flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // All flags clear, nothing pending
            status_reg <= ALARM_STATUS_TWO_RST;
        end else begin
            // Clears and sets already merged, sets winning
            status_reg <= status_next;
        end
    end

    // Shutdown re-arm: blocked after a clear until the temperature falls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Free to set after reset
            shutdown_armed_reg <= 1'b1;
        end else if (status_one_rd_stb && status_reg[LOCAL_SHUTDOWN_BIT]) begin
            // Clearing a standing flag disarms it
            shutdown_armed_reg <= 1'b0;
        end else if (monitor_tick && local_cooled) begin
            // Far enough below the limit, arm again
            shutdown_armed_reg <= 1'b1;
        end
    end

    // Shadow duty: every write lands here regardless of mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Same reset duty as the output
            duty_shadow_reg <= PWM_DUTY_CODE_RST;
        end else if (duty_wr) begin
            // Kept in every mode, used once direct
            duty_shadow_reg <= reg_wdata;
        end
    end

    // Direct mode takes the shadow; other modes keep it waiting
    always_comb begin
        if (mode == FASD_MODE_DIRECT) begin
            // Written code drives the output
            computed_duty = duty_shadow_reg;
        end else begin
            // Loop value; the written code waits
            computed_duty = loop_duty;
        end
    end

    // Full speed while an outside party holds the throttle pin low
    assign full_speed = ext_low;

    // Floor and cutoff; the computed value stays visible on reads
    always_comb begin
        duty_out_next = computed_duty;
        duty_forced = 1'b0;
        if (full_speed) begin
            // Outside pull overrides every mode
            duty_out_next = DUTY_FULL;
        end else if (!tach_sense_select) begin
            case (mode)
                FASD_MODE_RPM: begin
                    // Keep the fan turning while regulating
                    if (computed_duty < RPM_FLOOR_CODE) begin
                        duty_out_next = RPM_FLOOR_CODE;
                        duty_forced = 1'b1;
                    end
                end
                FASD_MODE_AUTO, FASD_MODE_DIRECT: begin
                    // Scaled compare avoids a fractional code
                    if (16'(computed_duty) * 16'(100) < LOW_CUTOFF_X100) begin
                        duty_out_next = DUTY_ZERO;
                        duty_forced = 1'b1;
                    end
                end
                default: begin
                    // Spare mode passes the loop value
                    duty_out_next = computed_duty;
                end
            endcase
        end
    end

    // Read back the computed value only in the two forced cases
    assign duty_readback = duty_forced ? computed_duty : duty_out_next;

    // Applied duty register feeding the pulse generator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // About one third duty
            applied_duty <= PWM_DUTY_CODE_RST;
        end else begin
            // One edge behind the inputs
            applied_duty <= duty_out_next;
        end
    end

    // Read data, captured in the same edge that clears the flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Idle read data
            reg_rdata <= 8'h00;
        end else if (reg_rd_stb) begin
            case (reg_addr)
                ALARM_STATUS_TWO_ADDR: begin
                    // Old flags go out as the clear lands
                    reg_rdata <= {status_reg[7:3], STATUS_RESERVED_VAL};
                end
                PWM_DUTY_CODE_ADDR: begin
                    // Computed value in the two forced cases
                    reg_rdata <= duty_readback;
                end
                default: begin
                    // Unmapped offsets read as zero
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // Alert and overlimit levels from the new flags
    always_comb begin
        alert_next = (status_next[LOCAL_SHUTDOWN_BIT] && shutdown_alert_enable)
            || (status_next[PASSIVE_COOLING_BIT] && passive_alert_enable)
            || status_next[LOCAL_CRITICAL_BIT]
            || status_next[REMOTE_CRITICAL_BIT];
        // Critical flags only; no enable applies
        overlimit_next = status_next[LOCAL_CRITICAL_BIT] || status_next[REMOTE_CRITICAL_BIT];
    end

    // Alert pin, registered so it cannot glitch between flag updates
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Released high, nothing to report
            smbalert_n <= 1'b1;
        end else begin
            // Low while any enabled or unmaskable cause stands
            smbalert_n <= !alert_next;
        end
    end

    // Overlimit pin, follows both critical flags
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Released high
            overlimit_pin_n <= 1'b1;
        end else begin
            // Released high as the flags clear on a status read
            overlimit_pin_n <= !overlimit_next;
        end
    end

    // Throttle pin, open drain: only ever pulls low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Line left to its pull-up
            overtemp_throttle_pin_out <= 1'b0;
            overtemp_throttle_pin_oe_n <= 1'b1;
        end else begin
            // Drive value fixed low; the enable does the work
            overtemp_throttle_pin_out <= 1'b0;
            // Enable drive only while the shutdown flag stands
            overtemp_throttle_pin_oe_n <= !status_next[LOCAL_SHUTDOWN_BIT];
        end
    end

    // Pulse generator
    // Runs free; a new code takes effect within one period
    fasd_pwm #(
        .WIDTH(8)
    ) u_pwm (
        .sys_clk(sys_clk),
        .rst(rst),
        .duty(applied_duty),
        .pwm_out(pulse_output_pin)
    );
endmodule

/* File: sim/fasd_host.sv */
// Host model: strobe register access and the pulled-up throttle line
`timescale 1ns/10ps
module fasd_host (
    input wire logic sys_clk, // Clock
    input wire logic [7:0] reg_rdata, // Read data
    output logic [7:0] reg_addr, // Offset
    output logic reg_wr_stb, // Write strobe
    output logic reg_rd_stb, // Read strobe
    output logic [7:0] reg_wdata, // Write data
    input wire logic ext_pull, // Outside pull low
    input wire logic pin_out, // Device drive value
    input wire logic pin_oe_n, // Device drive, low drives
    output logic pin_level // Resolved line
);
    // Pull-up wins unless some party pulls low
    assign pin_level = !(ext_pull || (!pin_oe_n && !pin_out));
    // Idle bus
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
    end
    // Strobe held for the one taking edge; data inverted after, not left valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr_stb = 1'b0;
        reg_wdata = ~d;
    endtask
    // Read data is taken just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
        reg_rd_stb = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

/* File: sim/fasd_monitor.sv */
// Port checker for alarm pins, read data and duty code
`timescale 1ns/10ps
module fasd_monitor import fasd_pkg::*; (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] reg_addr, // Offset
    input wire logic reg_wr_stb, // Write strobe
    input wire logic reg_rd_stb, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic monitor_tick, // Monitor pulse
    input wire logic signed [7:0] local_temp, // Local temp
    input wire logic signed [7:0] remote_temp, // Remote temp
    input wire logic signed [7:0] control_temp, // Control temp
    input wire logic signed [7:0] local_critical_limit, // Local limit
    input wire logic signed [7:0] remote_critical_limit, // Remote limit
    input wire logic signed [7:0] passive_temp, // Passive temp
    input wire logic passive_alert_enable, // Passive enable
    input wire logic tach_sense_select, // Tach select
    input wire logic [1:0] control_mode, // Mode
    input wire logic [7:0] loop_duty, // Loop duty
    input wire logic overtemp_throttle_pin_in, // Line level
    input wire logic overtemp_throttle_pin_oe_n, // Line drive
    input wire logic overlimit_pin_n, // Overlimit
    input wire logic smbalert_n, // Alert
    input wire logic [7:0] applied_duty // Applied duty
);
    // Direct mode with nothing overriding the written code
    wire dmode = control_mode == FASD_MODE_DIRECT && tach_sense_select && overtemp_throttle_pin_in;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Reset itself is the cause here, so no disable
    reset_load_a: assert property (disable iff (1'b0)
        rst |=> applied_duty == PWM_DUTY_CODE_RST && reg_rdata == 8'h00 && smbalert_n)
        else $error("Reset state wrong");
    rsvd_zero_a: assert property (
        reg_rd_stb && reg_addr == ALARM_STATUS_TWO_ADDR |=> reg_rdata[2:0] == STATUS_RESERVED_VAL)
        else $error("Reserved bits set");
    rdata_hold_a: assert property (!reg_rd_stb |=> $stable(reg_rdata))
        else $error("Read data moved");
    local_crit_a: assert property (
        monitor_tick && local_temp >= local_critical_limit |=> !overlimit_pin_n && !smbalert_n)
        else $error("Local critical pins idle");
    remote_crit_a: assert property (
        monitor_tick && remote_temp >= remote_critical_limit |=> !overlimit_pin_n && !smbalert_n)
        else $error("Remote critical pins idle");
    ext_full_a: assert property (
        !overtemp_throttle_pin_in && overtemp_throttle_pin_oe_n |=> applied_duty == DUTY_FULL)
        else $error("No full speed");
    // Shadow lands on the write edge, output one edge later
    direct_write_a: assert property (
        reg_wr_stb && reg_addr == PWM_DUTY_CODE_ADDR && dmode ##1 dmode |=> applied_duty == $past(reg_wdata, 2))
        else $error("Direct write not applied");
    rpm_floor_a: assert property (
        control_mode == FASD_MODE_RPM && !tach_sense_select && loop_duty < RPM_FLOOR_CODE
        && overtemp_throttle_pin_in |=> applied_duty == RPM_FLOOR_CODE)
        else $error("Floor not forced");
    passive_alert_a: assert property (
        monitor_tick && control_temp <= passive_temp && passive_alert_enable |=> !smbalert_n)
        else $error("Passive alert missing");
    crit_c: cover property (monitor_tick && local_temp >= local_critical_limit);
    ext_c: cover property (!overtemp_throttle_pin_in && overtemp_throttle_pin_oe_n);
    floor_c: cover property (control_mode == FASD_MODE_RPM && applied_duty == RPM_FLOOR_CODE);
endmodule

bind fasd_top fasd_monitor u_monitor (.sys_clk, .rst, .reg_addr, .reg_wr_stb, .reg_rd_stb, .reg_wdata,
    .reg_rdata, .monitor_tick, .local_temp, .remote_temp, .control_temp, .local_critical_limit,
    .remote_critical_limit, .passive_temp, .passive_alert_enable, .tach_sense_select, .control_mode,
    .loop_duty, .overtemp_throttle_pin_in, .overtemp_throttle_pin_oe_n, .overlimit_pin_n, .smbalert_n,
    .applied_duty);

/* File: sim/fasd_top_tb.sv */
// Self-checking bench for alarm status and duty registers
`timescale 1ns/10ps
module fasd_top_tb import fasd_pkg::*; ();
    logic sys_clk, rst, status_one_rd_stb, monitor_tick, shutdown_alert_enable, passive_alert_enable;
    logic signed [7:0] local_temp, remote_temp, control_temp, local_shutdown_limit;
    logic signed [7:0] local_critical_limit, remote_critical_limit, passive_temp;
    logic tach_sense_select, ext_pull, pin_level, reg_wr_stb, reg_rd_stb, pin_out, pin_oe_n;
    logic overlimit_pin_n, smbalert_n, pulse_output_pin;
    logic [1:0] control_mode;
    logic [7:0] loop_duty, reg_addr, reg_wdata, reg_rdata, applied_duty, v;
    int failures = 0, check_count = 0, cyc = 0, n;
    // Hysteresis walk: temp per tick, expected status
    logic [7:0] hy_t [5] = '{8'h51, 8'h4C, 8'h51, 8'h4B, 8'h51};
    logic [7:0] hy_e [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    // Mode table: mode, tach, code, expected output
    logic [1:0] dm_m [6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h3};
    logic dm_t [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [7:0] dm_v [6] = '{8'h20, 8'h20, 8'h11, 8'h12, 8'h11, 8'h11};
    logic [7:0] dm_a [6] = '{RPM_FLOOR_CODE, 8'h20, 8'h00, 8'h12, 8'h00, 8'h11};
    logic [7:0] pw [3] = '{8'h00, 8'h40, 8'hFF};
    fasd_top DUT (.sys_clk, .rst, .reg_addr, .reg_wr_stb, .reg_rd_stb, .reg_wdata, .reg_rdata,
        .status_one_rd_stb, .monitor_tick, .local_temp, .remote_temp, .control_temp, .local_shutdown_limit,
        .local_critical_limit, .remote_critical_limit, .passive_temp, .shutdown_alert_enable,
        .passive_alert_enable, .tach_sense_select, .control_mode, .loop_duty,
        .overtemp_throttle_pin_in(pin_level), .overtemp_throttle_pin_out(pin_out),
        .overtemp_throttle_pin_oe_n(pin_oe_n), .overlimit_pin_n, .smbalert_n, .pulse_output_pin, .applied_duty);
    fasd_host host (.sys_clk, .reg_rdata, .reg_addr, .reg_wr_stb, .reg_rd_stb, .reg_wdata, .ext_pull,
        .pin_out, .pin_oe_n, .pin_level);
    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, several times the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Step k edges, then land just after the last one
    task automatic cy(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    task automatic tk();
        cy(1);
        monitor_tick = 1'b1;
        cy(1);
        monitor_tick = 1'b0;
    endtask
    task automatic tkr(input logic [7:0] e);
        tk();
        rdc(8'h03, e);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {status_one_rd_stb, monitor_tick, shutdown_alert_enable, passive_alert_enable, ext_pull} = 5'h00;
        local_temp = 8'h19; // 25 C
        remote_temp = 8'h19;
        control_temp = 8'h19;
        local_shutdown_limit = 8'h50; // 80 C
        local_critical_limit = 8'h3C; // 60 C
        remote_critical_limit = 8'h5A; // 90 C
        passive_temp = 8'h0A; // 10 C
        tach_sense_select = 1'b1;
        control_mode = 2'h2;
        loop_duty = 8'h40;
        cy(4);
        rst = 1'b0;
        rdc(ALARM_STATUS_TWO_ADDR, ALARM_STATUS_TWO_RST);
        rdc(PWM_DUTY_CODE_ADDR, PWM_DUTY_CODE_RST);
        rdc(8'h10, 8'h00);
        host.wr(ALARM_STATUS_TWO_ADDR, 8'hFF);
        rdc(8'h03, 8'h00);
        $display("test reset done");
        // Both criticals at their limits
        local_temp = 8'h3C;
        remote_temp = 8'h5A;
        tk();
        chk(overlimit_pin_n, 1'b0);
        chk(smbalert_n, 1'b0);
        rdc(8'h03, 8'h18);
        rdc(8'h03, 8'h00);
        tkr(8'h18);
        tk();
        local_temp = 8'h19;
        remote_temp = 8'h19;
        tkr(8'h00);
        chk(overlimit_pin_n, 1'b1);
        $display("test critical done");
        // Passive at threshold, masked then enabled
        control_temp = 8'h0A;
        tk();
        chk(smbalert_n, 1'b1);
        passive_alert_enable = 1'b1;
        tk();
        chk(smbalert_n, 1'b0);
        rdc(8'h03, 8'h20);
        rdc(8'h03, 8'h00);
        control_temp = 8'h0B;
        tkr(8'h00);
        $display("test passive done");
        // Shutdown: strict compare, first-status clear, 5 degree rearm
        local_critical_limit = 8'h78;
        shutdown_alert_enable = 1'b1;
        local_temp = 8'h50;
        tkr(8'h00);
        local_temp = 8'h51;
        tkr(8'h40);
        rdc(8'h03, 8'h40);
        chk(pin_oe_n, 1'b0);
        chk(pin_out, 1'b0);
        chk(smbalert_n, 1'b0);
        status_one_rd_stb = 1'b1;
        cy(1);
        status_one_rd_stb = 1'b0;
        rdc(8'h03, 8'h00);
        chk(pin_oe_n, 1'b1);
        foreach (hy_t[i]) begin
            local_temp = hy_t[i];
            tkr(hy_e[i]);
        end
        local_temp = 8'h19;
        tkr(8'h00);
        $display("test shutdown done");
        // Outside party pulls the throttle line
        ext_pull = 1'b1;
        rdc(8'h03, 8'h80);
        chk(applied_duty, DUTY_FULL);
        rdc(8'h03, 8'h80);
        ext_pull = 1'b0;
        rdc(8'h03, 8'h80);
        rdc(8'h03, 8'h00);
        chk(applied_duty, PWM_DUTY_CODE_RST);
        $display("test pin done");
        // Direct write, then buffered write in auto mode
        host.wr(8'h22, 8'h80);
        cy(1);
        chk(applied_duty, 8'h80);
        rdc(8'h22, 8'h80);
        control_mode = 2'h0;
        host.wr(8'h22, 8'h33);
        cy(1);
        chk(applied_duty, 8'h40);
        rdc(8'h22, 8'h40);
        control_mode = 2'h2;
        cy(1);
        chk(applied_duty, 8'h33);
        foreach (dm_m[i]) begin
            control_mode = dm_m[i];
            tach_sense_select = dm_t[i];
            loop_duty = dm_v[i];
            host.wr(8'h22, dm_v[i]);
            cy(1);
            chk(applied_duty, dm_a[i]);
            rdc(8'h22, dm_v[i]);
        end
        $display("test duty done");
        // High clocks per 255-clock period equal the code
        tach_sense_select = 1'b1;
        control_mode = 2'h2;
        foreach (pw[i]) begin
            host.wr(8'h22, pw[i]);
            cy(257);
            n = 0;
            repeat (255) begin
                cy(1);
                if (pulse_output_pin === 1'b1) n++;
            end
            chk(8'(n), pw[i]);
        end
        $display("test pwm done");
        stop_test();
    end
endmodule
